// *** pkg/fss_defs.svh ***
`ifndef FSS_DEFS_SVH
`define FSS_DEFS_SVH

`define FSS_ADDR_CTRL     8'h00
`define FSS_ADDR_ENTRY    8'h04
`define FSS_ADDR_CF       8'h08
`define FSS_ADDR_STEP     8'h0c
`define FSS_ADDR_WIDTH    8'h10
`define FSS_ADDR_DISPLAY  8'h14
`define FSS_ADDR_OUT      8'h18
`define FSS_ADDR_STATUS   8'h1c
`define FSS_ADDR_REMOTE   8'h20

`define FSS_CTRL_MODE_LSB 0
`define FSS_CTRL_MODE_MSB 1
`define FSS_CTRL_RATE_LSB 2
`define FSS_CTRL_RATE_MSB 3
`define FSS_CTRL_STBY     4
`define FSS_REM_OP_LSB    0
`define FSS_REM_OP_MSB    1
`define FSS_REM_EXT       2
`define FSS_REM_OP_OLD    2'h1
`define FSS_REM_OP_NEW    2'h2
`define FSS_REM_OP_CMD    2'h3
`define FSS_RATE_SLOW     2'h0
`define FSS_RATE_FAST     2'h2

`define FSS_KEY_CF        0
`define FSS_KEY_UP        1
`define FSS_KEY_DN        2
`define FSS_KEY_WIDTH     3
`define FSS_KEY_SHIFT     4
`define FSS_KEY_MODE      5
`define FSS_KEY_SINGLE    6
`define FSS_KEY_ERROR     7
`define FSS_KNOB_CW       8
`define FSS_KNOB_CCW      9
`define FSS_NKEY          10

`define FSS_CF_RESET      32'h000f4240
`define FSS_HZ_1          34'h000000001
`define FSS_HZ_1K         34'h0000003e8
`define FSS_HZ_1M         34'h0000f4240
`define FSS_HZ_1300M      34'h04d7c6d00
`define FSS_ERR_FIRST     8'h01
`define FSS_ERR_LAST      8'h05
`define FSS_ERR_SWEEP     8'h05

`define FSS_CLK_HZ        25000000
`define FSS_T_STEP_MS     1
`define FSS_T_SLOW_MS     50
`define FSS_T_SHOW_MS     500
`define FSS_T_FLASH_MS    200
`define FSS_N_FAST        100
`define FSS_N_SLOW        1000
`define FSS_MAN_DIV       1000

`endif

// *** pkg/fss_pkg.sv ***
package fss_pkg;
	typedef enum logic [1:0] {SW_OFF, SW_AUTO, SW_SINGLE, SW_MANUAL} fss_sweep_e;
	typedef enum logic [1:0] {MAN_COARSE, MAN_MED, MAN_FINE, MAN_STEP} fss_man_e;
	typedef logic signed [33:0] fss_freq_t;
endpackage

// *** rtl/fss_ctrl.sv ***
// Summary of operation
// - Step-up key adds stored increment to center.
// - Value then step key loads increment only.
// - Shift then step shows increment briefly.
// - Center above upper limit rejected, range flashes.
// - Over-limit step-up flashes range once, holds.
// - Below lower limit accepted, range lamp steady.
// - Range lamp lights when output (auto/single sweep: center) below limit.
// - At or above 1300 MHz keep 2 Hz.
// - Mode key cycles tuning settings, step included.
// - Coarse knob detent moves center 1 MHz.
// - Fine knob detent moves center 1 Hz.
// - Auto sweep below limit blinks once per sweep.
// - Sweep stays centered on a stepped center.
// - Manual sweep knob stays within sweep band.
// - Single key sweeps once, display shows center.
// - Latch error codes 01-05 for redisplay.
// - After reset or legacy select, legacy only.
// - After extended select, extended commands only.
// - Increment kept until overwritten, reset, standby.
// - Manual sweep knob increment is width/1000.
// - Fast 100x1 ms, medium 1000x1 ms, slow 1000x50 ms.
`timescale 1ns/10ps
`default_nettype none
`include "fss_defs.svh"

module fss_ctrl
	import fss_pkg::*;
#(
	parameter int P_STEP_CYC  = `FSS_CLK_HZ / 1000 * `FSS_T_STEP_MS,
	parameter int P_SLOW_CYC  = `FSS_CLK_HZ / 1000 * `FSS_T_SLOW_MS,
	parameter int P_SHOW_CYC  = `FSS_CLK_HZ / 1000 * `FSS_T_SHOW_MS,
	parameter int P_FLASH_CYC = `FSS_CLK_HZ / 1000 * `FSS_T_FLASH_MS
)
(
	input  wire logic                 I_REF_CLK,
	input  wire logic                 I_NRST,
	input  wire logic                 I_PSEL,
	input  wire logic                 I_PENABLE,
	input  wire logic                 I_PWRITE,
	input  wire logic [7:0]           I_PADDR,
	input  wire logic [31:0]          I_PWDATA,
	output logic      [31:0]          O_PRDATA,
	output logic                      O_PREADY,
	output logic                      O_PSLVERR,
	input  wire logic [7:0]           I_KEY,
	input  wire logic                 I_KNOB_CW,
	input  wire logic                 I_KNOB_CCW,
	input  wire logic [31:0]          I_LIMIT_HI,
	input  wire logic [31:0]          I_LIMIT_LO,
	input  wire logic [7:0]           I_SELFTEST_ERR,
	output logic                      O_RANGE,
	output logic                      O_SWEEP,
	output logic      [31:0]          O_OUT_FREQ,
	output logic      [31:0]          O_DISPLAY
);

	function automatic logic err_latchable(input logic [7:0] code);
		err_latchable = (code >= `FSS_ERR_FIRST) && (code <= `FSS_ERR_LAST);
	endfunction
	// The register keeps 1 Hz; what is shown and sent out drops to 2 Hz high up.
	function automatic fss_freq_t res_round(input fss_freq_t f);
		res_round = (f >= `FSS_HZ_1300M) ? (f & ~`FSS_HZ_1) : f;
	endfunction
	logic [`FSS_NKEY-1:0] key_s1;
	logic [`FSS_NKEY-1:0] key_s2;
	logic [`FSS_NKEY-1:0] key_s3;
	logic [`FSS_NKEY-1:0] key_lvl;
	logic [`FSS_NKEY-1:0] kev;
	logic [71:0]          cfg_s1;
	logic [71:0]          cfg_s2;
	logic [71:0]          cfg_s3;
	logic [71:0]          cfg;
	logic [31:0]          ctrl;
	logic [31:0]          entry;
	logic                 pending;
	logic [31:0]          cf;
	logic [31:0]          step;
	logic [31:0]          width;
	logic                 shift_arm;
	fss_man_e             man_set;
	fss_freq_t            man_off;
	logic                 sw_run;
	logic [9:0]           sw_idx;
	logic [20:0]          sw_dwell;
	logic [31:0]          sw_off;
	logic                 blinked;
	logic [23:0]          flash_cnt;
	logic [23:0]          show_cnt;
	logic [31:0]          show_val;
	logic [7:0]           err_code;
	logic                 fmt_ext;
	logic                 cmd_ok;
	// Pin inputs: three flops, a change counts once stages two and three agree.
	wire [`FSS_NKEY-1:0] key_raw = {I_KNOB_CCW, I_KNOB_CW, I_KEY};
	genvar g;
	generate
		for (g = 0; g < `FSS_NKEY; g++)
		begin : g_key
			always_ff @(posedge I_REF_CLK or negedge I_NRST)
			begin
				if (!I_NRST)
				begin
					key_s1[g]  <= 1'b0;
					key_s2[g]  <= 1'b0;
					key_s3[g]  <= 1'b0;
					key_lvl[g] <= 1'b0;
				end
				else
				begin
					key_s1[g] <= key_raw[g];
					key_s2[g] <= key_s1[g];
					key_s3[g] <= key_s2[g];
					if (key_s2[g] == key_s3[g])
						key_lvl[g] <= key_s3[g];
				end
			end
			assign kev[g] = (key_s2[g] == key_s3[g]) && key_s3[g] && !key_lvl[g];
		end
	endgenerate
	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			cfg_s1 <= 72'h0;
			cfg_s2 <= 72'h0;
			cfg_s3 <= 72'h0;
			cfg    <= 72'h0;
		end
		else
		begin
			cfg_s1 <= {I_SELFTEST_ERR, I_LIMIT_LO, I_LIMIT_HI};
			cfg_s2 <= cfg_s1;
			cfg_s3 <= cfg_s2;
			if (cfg_s2 == cfg_s3)
				cfg <= cfg_s3;
		end
	end
	wire fss_freq_t lim_hi = {2'b00, cfg[31:0]};
	wire fss_freq_t lim_lo = {2'b00, cfg[63:32]};
	wire [7:0]      st_err = cfg[71:64];
	// Register bus decode.
	wire acc_fire  = I_PSEL && I_PENABLE && O_PREADY;
	wire wr_fire   = acc_fire && I_PWRITE;
	wire wr_ctrl   = wr_fire && (I_PADDR == `FSS_ADDR_CTRL);
	wire wr_entry  = wr_fire && (I_PADDR == `FSS_ADDR_ENTRY);
	wire wr_remote = wr_fire && (I_PADDR == `FSS_ADDR_REMOTE);
	wire [1:0] rem_op = I_PWDATA[`FSS_REM_OP_MSB:`FSS_REM_OP_LSB];
	wire [31:0] status = {16'h0, err_code, 1'b0, cmd_ok, pending, fmt_ext,
		man_set, sw_run, O_RANGE};
	wire addr_ok = (I_PADDR <= `FSS_ADDR_REMOTE) && (I_PADDR[1:0] == 2'h0);
	wire [31:0] rd_val =
		(I_PADDR == `FSS_ADDR_CTRL)    ? ctrl :
		(I_PADDR == `FSS_ADDR_ENTRY)   ? entry :
		(I_PADDR == `FSS_ADDR_CF)      ? cf :
		(I_PADDR == `FSS_ADDR_STEP)    ? step :
		(I_PADDR == `FSS_ADDR_WIDTH)   ? width :
		(I_PADDR == `FSS_ADDR_DISPLAY) ? O_DISPLAY :
		(I_PADDR == `FSS_ADDR_OUT)     ? O_OUT_FREQ :
		(I_PADDR == `FSS_ADDR_STATUS)  ? status : 32'h0;
	wire fss_sweep_e mode = fss_sweep_e'(ctrl[`FSS_CTRL_MODE_MSB:`FSS_CTRL_MODE_LSB]);
	wire [1:0] rate = ctrl[`FSS_CTRL_RATE_MSB:`FSS_CTRL_RATE_LSB];
	wire standby = ctrl[`FSS_CTRL_STBY];
	// Panel event decode.
	wire step_key  = kev[`FSS_KEY_UP] || kev[`FSS_KEY_DN];
	wire show_step = step_key && shift_arm;
	wire load_step = step_key && !shift_arm && pending;
	wire do_step   = step_key && !shift_arm && !pending;
	wire load_cf   = kev[`FSS_KEY_CF] && pending;
	wire load_wid  = kev[`FSS_KEY_WIDTH] && pending;
	wire knob      = kev[`FSS_KNOB_CW] || kev[`FSS_KNOB_CCW];
	wire knob_man  = knob && (mode == SW_MANUAL);
	wire knob_cf   = knob && (mode != SW_MANUAL) && !step_key;
	wire show_err  = kev[`FSS_KEY_ERROR] && shift_arm;
	wire other_key = |(kev & ~(`FSS_NKEY'(1) << `FSS_KEY_SHIFT));
	wire fss_freq_t cf_w   = {2'b00, cf};
	wire fss_freq_t step_w = {2'b00, step};
	wire fss_freq_t half   = {3'b000, width[31:1]};
	wire fss_freq_t man_delta =
		(man_set == MAN_COARSE) ? `FSS_HZ_1M :
		(man_set == MAN_MED)    ? `FSS_HZ_1K :
		(man_set == MAN_FINE)   ? `FSS_HZ_1 : step_w;
	wire fss_freq_t delta = do_step ? step_w : man_delta;
	wire go_up = do_step ? kev[`FSS_KEY_UP] : kev[`FSS_KNOB_CW];
	wire fss_freq_t cand =
		load_cf ? {2'b00, entry} : (go_up ? cf_w + delta : cf_w - delta);
	wire freq_chg = load_cf || do_step || knob_cf;
	wire reject   = freq_chg && ((cand < 0) || (cand > lim_hi));
	wire fss_freq_t cf_rd  = res_round(cf_w);
	// Sweep arithmetic.
	wire [31:0] inc_fast = width / `FSS_N_FAST;
	wire [31:0] inc_slow = width / `FSS_N_SLOW;
	wire [31:0] man_inc  = width / `FSS_MAN_DIV;
	wire        fast     = (rate >= `FSS_RATE_FAST);
	wire [31:0] sw_inc   = fast ? inc_fast : inc_slow;
	wire [9:0]  sw_last  = fast ? 10'(`FSS_N_FAST - 1) : 10'(`FSS_N_SLOW - 1);
	wire [20:0] dwell_top = (rate == `FSS_RATE_SLOW) ? 21'(P_SLOW_CYC - 1)
		: 21'(P_STEP_CYC - 1);
	wire sw_mode  = (mode == SW_AUTO) || (mode == SW_SINGLE);
	wire sw_start = !sw_run && ((mode == SW_AUTO)
		|| ((mode == SW_SINGLE) && kev[`FSS_KEY_SINGLE]));
	wire sw_stepd = sw_run && (sw_dwell == dwell_top);
	wire sw_end   = sw_stepd && (sw_idx == sw_last);
	wire fss_freq_t man_up = man_off + {2'b00, man_inc};
	wire fss_freq_t man_dn = man_off - {2'b00, man_inc};
	wire fss_freq_t next_man = kev[`FSS_KNOB_CW] ? man_up : man_dn;
	wire man_ok = (next_man <= half) && (next_man >= -half);
	wire fss_freq_t out_raw =
		(sw_mode && sw_run)   ? cf_w - half + {2'b00, sw_off} :
		(mode == SW_MANUAL)   ? cf_w + man_off : cf_w;
	wire fss_freq_t out_c = (out_raw < 0) ? '0 : out_raw;
	wire fss_freq_t out_r = res_round(out_c);
	wire out_low  = out_c < lim_lo;
	wire cf_low   = cf_w < lim_lo;
	wire sw_bad   = (mode != SW_OFF) && ((cf_w < half) || (cf_w + half > lim_hi));
	wire blink    = sw_run && out_low && !blinked;
	wire [7:0] next_err = sw_bad ? `FSS_ERR_SWEEP
		: (err_latchable(st_err) ? st_err : err_code);
	wire next_range = (flash_cnt != 24'h0)
		|| (sw_mode ? cf_low : out_low);

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			O_PREADY  <= 1'b0;
			O_PRDATA  <= 32'h0;
			O_PSLVERR <= 1'b0;
		end
		else
		begin
			O_PREADY <= I_PSEL && I_PENABLE && !O_PREADY;
			if (I_PSEL && I_PENABLE && !O_PREADY)
			begin
				O_PRDATA  <= I_PWRITE ? 32'h0 : rd_val;
				O_PSLVERR <= !addr_ok;
			end
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			ctrl    <= 32'h0;
			entry   <= 32'h0;
			pending <= 1'b0;
			fmt_ext <= 1'b0;
			cmd_ok  <= 1'b1;
		end
		else
		begin
			if (wr_ctrl)
				ctrl <= I_PWDATA;
			if (wr_entry)
				entry <= I_PWDATA;
			pending <= wr_entry || (pending && !(load_cf || load_step || load_wid));
			if (wr_remote && (rem_op == `FSS_REM_OP_OLD))
				fmt_ext <= 1'b0;
			else if (wr_remote && (rem_op == `FSS_REM_OP_NEW))
				fmt_ext <= 1'b1;
			if (wr_remote && (rem_op == `FSS_REM_OP_CMD))
				cmd_ok <= (I_PWDATA[`FSS_REM_EXT] == fmt_ext);
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			cf        <= `FSS_CF_RESET;
			step      <= 32'h0;
			width     <= 32'h0;
			shift_arm <= 1'b0;
			man_set   <= MAN_COARSE;
			err_code  <= 8'h0;
		end
		else
		begin
			if (freq_chg && !reject)
				cf <= cand[31:0];
			if (standby)
				step <= 32'h0;
			else if (load_step)
				step <= entry;
			if (load_wid)
				width <= entry;
			shift_arm <= kev[`FSS_KEY_SHIFT] || (shift_arm && !other_key);
			if (kev[`FSS_KEY_MODE])
				man_set <= fss_man_e'(man_set + 2'h1);
			err_code <= next_err;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			sw_run   <= 1'b0;
			sw_idx   <= 10'h0;
			sw_dwell <= 21'h0;
			sw_off   <= 32'h0;
			blinked  <= 1'b0;
			man_off  <= '0;
		end
		else
		begin
			if (!sw_mode || sw_start || (sw_end && mode == SW_SINGLE))
			begin
				sw_run   <= sw_start;
				sw_idx   <= 10'h0;
				sw_dwell <= 21'h0;
				sw_off   <= 32'h0;
			end
			else if (sw_end)
			begin
				sw_idx   <= 10'h0;
				sw_dwell <= 21'h0;
				sw_off   <= 32'h0;
			end
			else if (sw_stepd)
			begin
				sw_idx   <= sw_idx + 10'h1;
				sw_dwell <= 21'h0;
				sw_off   <= sw_off + sw_inc;
			end
			else if (sw_run)
				sw_dwell <= sw_dwell + 21'h1;
			blinked <= !(sw_start || sw_end) && (blinked || blink);
			if ((mode != SW_MANUAL) || load_wid)
				man_off <= '0;
			else if (knob_man && man_ok)
				man_off <= next_man;
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST)
	begin
		if (!I_NRST)
		begin
			flash_cnt  <= 24'h0;
			show_cnt   <= 24'h0;
			show_val   <= 32'h0;
			O_RANGE    <= 1'b0;
			O_SWEEP    <= 1'b0;
			O_OUT_FREQ <= `FSS_CF_RESET;
			O_DISPLAY  <= `FSS_CF_RESET;
		end
		else
		begin
			if (reject || blink)
				flash_cnt <= 24'(P_FLASH_CYC);
			else if (flash_cnt != 24'h0)
				flash_cnt <= flash_cnt - 24'h1;
			if (show_step || show_err)
			begin
				show_cnt <= 24'(P_SHOW_CYC);
				show_val <= show_step ? step : {24'h0, err_code};
			end
			else if (show_cnt != 24'h0)
				show_cnt <= show_cnt - 24'h1;
			O_RANGE    <= next_range;
			O_SWEEP    <= mode != SW_OFF;
			O_OUT_FREQ <= out_r[31:0];
			O_DISPLAY  <= (show_cnt != 24'h0) ? show_val : cf_rd[31:0];
		end
	end
	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_NRST);

	chk_step_adds: assert property (do_step && kev[`FSS_KEY_UP] && !reject
		&& (cand < `FSS_HZ_1300M) |=> cf == $past(cf) + $past(step))
		else $error("step up did not add the increment");
	chk_step_load: assert property (load_step && !standby |=>
		$stable(cf) && (step == $past(entry)))
		else $error("increment load disturbed the center");
	chk_over_reject: assert property (reject |=> $stable(cf) ##1 O_RANGE)
		else $error("overrange center not rejected with flash");
	chk_low_steady: assert property ((mode == SW_OFF) && cf_low && $stable(cf)
		&& $stable(mode) |=> O_RANGE)
		else $error("range lamp off below lower limit");
	chk_even_high: assert property (O_OUT_FREQ >= `FSS_HZ_1300M |-> !O_OUT_FREQ[0])
		else $error("odd hertz above 1300 MHz");
	chk_knob_coarse: assert property (knob_cf && kev[`FSS_KNOB_CW]
		&& (man_set == MAN_COARSE) && !reject && (cand < `FSS_HZ_1300M)
		|=> cf == $past(cf) + 32'(`FSS_HZ_1M))
		else $error("coarse detent not 1 MHz");
	chk_man_band: assert property ((mode == SW_MANUAL) && $stable(mode)
		|-> (man_off <= half) && (man_off >= -half))
		else $error("manual sweep outside band");
	chk_fmt_ext: assert property (wr_remote && (rem_op == `FSS_REM_OP_NEW)
		|=> fmt_ext ##1 fmt_ext)
		else $error("extended format not selected");
	chk_show_back: assert property (show_step |=> (show_cnt != 24'h0) ##1
		(O_DISPLAY == $past(show_val)))
		else $error("increment not shown");
endmodule
`default_nettype wire

// *** test/fss_panel_model.sv ***
`timescale 1ns/10ps
`default_nettype none

module fss_panel_model
(
	input  wire logic       i_clk,
	output logic      [7:0] o_key,
	output logic            o_knob_cw,
	output logic            o_knob_ccw
);
	initial
	begin
		o_key = 8'h00;
		o_knob_cw = 1'b0;
		o_knob_ccw = 1'b0;
	end

	// A press or detent is high for four edges, then low for eight.
	task automatic press(input int idx);
		o_key[idx % 8] <= (idx < 8);
		o_knob_cw <= (idx == 8);
		o_knob_ccw <= (idx == 9);
		repeat (4) @(posedge i_clk);
		o_key <= 8'h00;
		o_knob_cw <= 1'b0;
		o_knob_ccw <= 1'b0;
		repeat (8) @(posedge i_clk);
	endtask
endmodule
`default_nettype wire

// *** test/test_frequency_step_sweep_control.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "fss_defs.svh"

module test_frequency_step_sweep_control;
	logic        clk;
	logic        nrst;
	logic        psel;
	logic        pen;
	logic        pwr;
	logic [7:0]  padr;
	logic [31:0] pwd;
	logic [31:0] prd;
	logic        prdy;
	logic        perr;
	logic [7:0]  key;
	logic        kcw;
	logic        kccw;
	logic [31:0] lim_hi;
	logic [31:0] lim_lo;
	logic [7:0]  st_err;
	logic        rng;
	logic        swp;
	logic [31:0] outf;
	logic [31:0] disp;
	logic [31:0] rq;
	logic        re;
	logic [31:0] cf;
	logic [31:0] stp;
	logic [31:0] o0;
	logic [31:0] seed;
	logic [31:0] lo_s;
	logic [31:0] hi_s;
	logic        rng_d;
	logic        fmt;
	logic [31:0] dlt [4];
	logic [7:0]  bad [2] = '{8'h24, 8'h02};
	logic [2:0]  rw [8]  = '{3'h3, 3'h7, 3'h2, 3'h3, 3'h7, 3'h1, 3'h7, 3'h3};
	logic [31:0] rate [3] = '{32'h2, 32'h1, 32'h0};
	int          dur [3]  = '{400, 4000, 8000};
	int          n_rise;
	int          num_errors;
	int          n_tests;

	fss_ctrl #(
		.P_STEP_CYC  (4),
		.P_SLOW_CYC  (8),
		.P_SHOW_CYC  (20),
		.P_FLASH_CYC (10)
	) fss_ctrl_inst (
		.I_REF_CLK      (clk),
		.I_NRST         (nrst),
		.I_PSEL         (psel),
		.I_PENABLE      (pen),
		.I_PWRITE       (pwr),
		.I_PADDR        (padr),
		.I_PWDATA       (pwd),
		.O_PRDATA       (prd),
		.O_PREADY       (prdy),
		.O_PSLVERR      (perr),
		.I_KEY          (key),
		.I_KNOB_CW      (kcw),
		.I_KNOB_CCW     (kccw),
		.I_LIMIT_HI     (lim_hi),
		.I_LIMIT_LO     (lim_lo),
		.I_SELFTEST_ERR (st_err),
		.O_RANGE        (rng),
		.O_SWEEP        (swp),
		.O_OUT_FREQ     (outf),
		.O_DISPLAY      (disp)
	);

	fss_panel_model fss_panel_model_inst (
		.i_clk      (clk),
		.o_key      (key),
		.o_knob_cw  (kcw),
		.o_knob_ccw (kccw)
	);

	always #20 clk = ~clk;

	always @(posedge clk)
	begin
		if (rng === 1'b1 && rng_d !== 1'b1)
			n_rise++;
		rng_d = rng;
		if (outf < lo_s)
			lo_s = outf;
		if (outf > hi_s)
			hi_s = outf;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [31:0] exp_cf(input logic [31:0] v);
		if (v > lim_hi)
			return cf;
		return v;
	endfunction

	function automatic logic [31:0] dsp(input logic [31:0] v);
		if (v >= `FSS_HZ_1300M)
			return v & 32'hfffffffe;
		return v;
	endfunction

	task automatic give_verdict();
		$display("Compares %0d, errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			num_errors++;
			$display("[ERR] %0t value %h, expected %h", $time, s, e);
		end
	endtask

	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask

	task automatic clr();
		n_rise = 0;
		lo_s = 32'hffffffff;
		hi_s = 32'h0;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (prdy !== 1'b1 && n < 16);
		rq = prd;
		re = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		if (prdy !== 1'b1)
		begin
			num_errors++;
			give_verdict();
		end
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rq, e);
	endtask

	task automatic pk(input int i);
		fss_panel_model_inst.press(i);
	endtask

	task automatic ent(input logic [31:0] v, input int k);
		apb(1'b1, `FSS_ADDR_ENTRY, v);
		pk(k);
	endtask

	initial
	begin
		clk = 1'b0;
		nrst = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		padr = 8'h00;
		pwd = 32'h0;
		lim_hi = 32'h068e777f;
		lim_lo = 32'h00002710;
		st_err = 8'h03;
		seed = 32'h240bc256;
		fmt = 1'b0;
		rng_d = 1'b0;
		num_errors = 0;
		n_tests = 0;
		clr();
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		chk(disp, `FSS_CF_RESET);
		foreach (bad[i])
		begin
			apb(1'b0, bad[i], 32'h0);
			chk({rq[31:1], re}, 32'h1);
		end
		apb(1'b1, `FSS_ADDR_CF, 32'h0);
		rd(`FSS_ADDR_CF, `FSS_CF_RESET);
		pk(`FSS_KEY_SHIFT);
		pk(`FSS_KEY_ERROR);
		chk(disp, 32'h3);
		st_err <= 8'h00;
		ent(32'h067f3540, `FSS_KEY_CF);
		cf = 32'h067f3540;
		ent(32'h0001b207, `FSS_KEY_UP);
		stp = 32'h0001b207;
		rd(`FSS_ADDR_STEP, stp);
		chk(disp, cf);
		pk(`FSS_KEY_SHIFT);
		pk(`FSS_KEY_DN);
		chk(disp, stp);
		repeat (20) @(posedge clk);
		chk(disp, cf);
		for (int i = 0; i < 9; i++)
		begin
			pk(`FSS_KEY_UP);
			cf = exp_cf(cf + stp);
			chk(disp, cf);
		end
		clr();
		pk(`FSS_KEY_UP);
		chk(disp, cf);
		chk(n_rise, 32'h1);
		repeat (12) @(posedge clk);
		chk({31'h0, rng}, 32'h0);
		for (int i = 0; i < 6; i++)
		begin
			o0 = xs() % 32'h08000000;
			ent(o0, `FSS_KEY_CF);
			cf = exp_cf(o0);
			rd(`FSS_ADDR_CF, cf);
		end
		ent(32'h02faf080, `FSS_KEY_CF);
		cf = 32'h02faf080;
		dlt = '{32'h000f4240, 32'h000003e8, 32'h00000001, stp};
		for (int s = 0; s < 4; s++)
		begin
			apb(1'b0, `FSS_ADDR_STATUS, 32'h0);
			chk(rq[3:2], s[1:0]);
			pk(`FSS_KNOB_CW);
			cf = cf + dlt[s];
			chk(disp, cf);
			pk(`FSS_KNOB_CCW);
			cf = cf - dlt[s];
			chk(disp, cf);
			pk(`FSS_KEY_MODE);
		end
		ent(32'h00000bb8, `FSS_KEY_CF);
		repeat (30) @(posedge clk);
		ok(rng);
		ent(32'h00000064, `FSS_KEY_DN);
		stp = 32'h00000064;
		pk(`FSS_KEY_DN);
		chk(disp, 32'h00000b54);
		ok(rng);
		lim_hi <= 32'h9af8da00;
		ent(32'h9502f900, `FSS_KEY_CF);
		cf = 32'h9502f900;
		ent(32'h00a98ac7, `FSS_KEY_UP);
		stp = 32'h00a98ac7;
		for (int i = 0; i < 10; i++)
		begin
			pk(`FSS_KEY_UP);
			cf = exp_cf(cf + stp);
			chk(disp, dsp(cf));
			chk(outf, dsp(cf));
		end
		ent(32'h02faf080, `FSS_KEY_CF);
		cf = 32'h02faf080;
		lim_hi <= 32'h068e777f;
		ent(32'h00002710, `FSS_KEY_WIDTH);
		rd(`FSS_ADDR_WIDTH, 32'h00002710);
		apb(1'b1, `FSS_ADDR_CTRL, 32'h3);
		repeat (4) @(posedge clk);
		ok(swp);
		o0 = outf;
		pk(`FSS_KNOB_CW);
		chk(outf, o0 + 32'ha);
		for (int i = 0; i < 1010; i++)
			pk(`FSS_KNOB_CW);
		chk(outf, cf + 32'h1388);
		rd(`FSS_ADDR_CF, cf);
		ent(32'h000f4240, `FSS_KEY_WIDTH);
		apb(1'b1, `FSS_ADDR_CTRL, 32'h9);
		repeat (10) @(posedge clk);
		clr();
		repeat (450) @(posedge clk);
		chk(lo_s, cf - 32'h7a120);
		ok(hi_s <= cf + 32'h7a120 && hi_s >= cf + 32'h77a10);
		ent(32'h004c4b40, `FSS_KEY_UP);
		stp = 32'h004c4b40;
		pk(`FSS_KEY_UP);
		cf = cf + stp;
		repeat (10) @(posedge clk);
		clr();
		repeat (450) @(posedge clk);
		chk(lo_s, cf - 32'h7a120);
		chk(disp, cf);
		ent(32'h00002710, `FSS_KEY_CF);
		ent(32'h00002710, `FSS_KEY_WIDTH);
		repeat (10) @(posedge clk);
		clr();
		repeat (1210) @(posedge clk);
		ok(n_rise >= 3 && n_rise <= 4);
		ent(32'h000f4240, `FSS_KEY_WIDTH);
		repeat (4) @(posedge clk);
		apb(1'b0, `FSS_ADDR_STATUS, 32'h0);
		chk(rq[15:8], `FSS_ERR_SWEEP);
		apb(1'b1, `FSS_ADDR_CTRL, 32'h0);
		ent(32'h02faf080, `FSS_KEY_CF);
		cf = 32'h02faf080;
		ent(32'h000186a0, `FSS_KEY_WIDTH);
		for (int r = 0; r < 3; r++)
		begin
			apb(1'b1, `FSS_ADDR_CTRL, 32'h2 | (rate[r] << 2));
			repeat (4) @(posedge clk);
			chk(outf, cf);
			clr();
			pk(`FSS_KEY_SINGLE);
			repeat (dur[r] - 40) @(posedge clk);
			ok(outf !== cf);
			chk(disp, cf);
			repeat (60) @(posedge clk);
			chk(outf, cf);
			chk(lo_s, cf - 32'hc350);
		end
		for (int i = 0; i < 8; i++)
		begin
			apb(1'b1, `FSS_ADDR_REMOTE, {29'h0, rw[i]});
			if (rw[i][1:0] == `FSS_REM_OP_NEW)
				fmt = 1'b1;
			if (rw[i][1:0] == `FSS_REM_OP_OLD)
				fmt = 1'b0;
			apb(1'b0, `FSS_ADDR_STATUS, 32'h0);
			chk(rq[4], fmt);
			if (rw[i][1:0] == `FSS_REM_OP_CMD)
				chk(rq[6], rw[i][2] == fmt);
		end
		rd(`FSS_ADDR_STEP, stp);
		apb(1'b1, `FSS_ADDR_CTRL, 32'h10);
		rd(`FSS_ADDR_CTRL, 32'h10);
		rd(`FSS_ADDR_STEP, 32'h0);
		apb(1'b1, `FSS_ADDR_CTRL, 32'h0);
		ent(32'h00000064, `FSS_KEY_UP);
		apb(1'b1, `FSS_ADDR_REMOTE, 32'h2);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		repeat (8) @(posedge clk);
		rd(`FSS_ADDR_STEP, 32'h0);
		apb(1'b0, `FSS_ADDR_STATUS, 32'h0);
		chk(rq[4], 1'b0);
		chk(disp, `FSS_CF_RESET);
		give_verdict();
	end
endmodule
`default_nettype wire
